// >>> mal_pkg.sv
// Purpose: Shared constants for the analog and segment port block
// Assumes: Byte addressed Avalon-MM, one register per 32-bit word
// Notes: Byte address is four times the register index
package mal_pkg;
    localparam int MAL_PORT_W = 8;
    localparam int MAL_ADDR_W = 8;
    // Register indices
    localparam logic [5:0] MAL_IDX_ANA_LATCH = 6'h06;
    localparam logic [5:0] MAL_IDX_SEG_LATCH = 6'h07;
    localparam logic [5:0] MAL_IDX_ANA_DIR = 6'h0c;
    localparam logic [5:0] MAL_IDX_SEG_PIN = 6'h0d;
    localparam logic [5:0] MAL_IDX_SEG_SEL = 6'h2b;
    localparam logic [5:0] MAL_IDX_CONV_CTRL = 6'h30;
    // Field position of the converter pin-select flag
    localparam int MAL_CONV_SEL_BIT = 0;
    // Reset values
    localparam logic [7:0] MAL_RST_ANA_LATCH = 8'h00;
    localparam logic [7:0] MAL_RST_SEG_LATCH = 8'hff;
    localparam logic [7:0] MAL_RST_ANA_DIR = 8'h00;
    localparam logic [7:0] MAL_RST_SEG_SEL = 8'h00;
    localparam logic MAL_RST_CONV_SEL = 1'b1;
    localparam logic [31:0] MAL_RD_UNMAPPED = 32'h0000_0000;
endpackage : mal_pkg

// >>> mal_io_ports.sv
// Purpose: Analog-capable port and segment-capable port with registers
// Assumes: Avalon-MM slave, byte address = 4 * register index
// Notes: Converter and LCD driver live outside; pins are split i/o/oe
//
// Behaviour
// R1: Eight analog-port pins, per-bit direction
// R2: Reset clears direction, latch; sets select flag
// R3: Reset configuration forces internal inputs zero
// R4: Software sets latch 1, direction 0 for inputs
// R5: Software sets direction 1 for output
// R6: Software clears latch and direction for analog
// R7: Latch, direction, flag pick input/zero/analog/output
// R8: Analog-mode bits read back as zero
// R9: Wake-key pins keep direction zero
// R10: No read-modify-write on analog latch
// R11: Never drive a pin used as analog
// R12: Avoid port writes during conversion
// R13: Reset sets segment latch all ones
// R14: Write latch one before segment-port input
// R15: Segment-select routes pin to LCD or I/O
// R16: Separate latch and pin-read addresses
// R17: Pin read of segment pin is undefined
// R18: Output pins driven from latch value
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
module mal_io_ports
    import mal_pkg::*;
#(
    parameter int PORT_W = MAL_PORT_W
) (
    input wire logic i_clk, // 25 MHz system clock
    input wire logic i_sys_rst, // Synchronous reset, active high
    input wire logic [MAL_ADDR_W-1:0] i_avs_address, // Byte address
    input wire logic i_avs_read, // Read request
    input wire logic i_avs_write, // Write request
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [3:0] i_avs_byteenable, // Byte lanes
    output logic [31:0] o_avs_readdata, // Read data
    output logic o_avs_waitrequest, // Stall
    input wire logic [PORT_W-1:0] i_ana_pin, // Analog port pin levels
    output logic [PORT_W-1:0] o_ana_pin, // Analog port pin drive
    output logic [PORT_W-1:0] o_ana_pin_oe, // Analog port drive enable
    output logic [PORT_W-1:0] o_ana_digital_in, // To int/counter/wake
    output logic [PORT_W-1:0] o_ana_conv_en, // Pin usable as AD input
    input wire logic [PORT_W-1:0] i_seg_pin, // Segment port pin levels
    output logic [PORT_W-1:0] o_seg_pin, // Segment port pin drive
    output logic [PORT_W-1:0] o_seg_pin_oe, // Segment port drive enable
    output logic [PORT_W-1:0] o_seg_lcd_route // Pin given to LCD driver
);
    logic [PORT_W-1:0] ana_latch_q;
    logic [PORT_W-1:0] ana_dir_q;
    logic conv_sel_q;
    logic [PORT_W-1:0] seg_latch_q;
    logic [PORT_W-1:0] seg_sel_q;
    logic [PORT_W-1:0] ana_s1_q, ana_s2_q, ana_s3_q, ana_flt_q;
    logic [PORT_W-1:0] seg_s1_q, seg_s2_q, seg_s3_q, seg_flt_q;
    logic [PORT_W-1:0] ana_in_mode;
    logic [PORT_W-1:0] ana_analog_mode;
    logic [PORT_W-1:0] ana_rd;
    logic [5:0] idx;
    logic wr_lane0;
    logic rd_pend_q;
    logic rd_start;
    logic [31:0] rd_d;
    logic [31:0] rd_q;

    function automatic logic [31:0] zext(input logic [PORT_W-1:0] v);
        zext = 32'h0000_0000;
        zext[PORT_W-1:0] = v;
    endfunction : zext

    assign idx = i_avs_address[7:2];
    assign wr_lane0 = i_avs_write && i_avs_byteenable[0];

    // Pin inputs: three stages, value moves once stages two and three agree
    always_ff @(posedge i_clk) begin
        ana_s1_q <= i_ana_pin;
        ana_s2_q <= ana_s1_q;
        ana_s3_q <= ana_s2_q;
        seg_s1_q <= i_seg_pin;
        seg_s2_q <= seg_s1_q;
        seg_s3_q <= seg_s2_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ana_flt_q <= '0;
            seg_flt_q <= '0;
        end else begin
            for (int i = 0; i < PORT_W; i++) begin
                if (ana_s2_q[i] == ana_s3_q[i]) begin
                    ana_flt_q[i] <= ana_s3_q[i];
                end
                if (seg_s2_q[i] == seg_s3_q[i]) begin
                    seg_flt_q[i] <= seg_s3_q[i];
                end
            end
        end
    end

    // Analog port control registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ana_latch_q <= MAL_RST_ANA_LATCH; // R2
            ana_dir_q <= MAL_RST_ANA_DIR; // R2
            conv_sel_q <= MAL_RST_CONV_SEL; // R2
        end else if (wr_lane0) begin
            case (idx)
                MAL_IDX_ANA_LATCH: begin
                    ana_latch_q <= i_avs_writedata[PORT_W-1:0]; // R18
                end
                MAL_IDX_ANA_DIR: begin
                    ana_dir_q <= i_avs_writedata[PORT_W-1:0]; // R1
                end
                MAL_IDX_CONV_CTRL: begin
                    conv_sel_q <= i_avs_writedata[MAL_CONV_SEL_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Segment port control registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            seg_latch_q <= MAL_RST_SEG_LATCH; // R13
            seg_sel_q <= MAL_RST_SEG_SEL;
        end else if (wr_lane0) begin
            case (idx)
                MAL_IDX_SEG_LATCH: begin
                    seg_latch_q <= i_avs_writedata[PORT_W-1:0]; // R18
                end
                MAL_IDX_SEG_SEL: begin
                    seg_sel_q <= i_avs_writedata[PORT_W-1:0]; // R15
                end
                default: begin
                end
            endcase
        end
    end

    // Per-pin mode of the analog port
    assign ana_in_mode = ~ana_dir_q & ana_latch_q; // R7
    assign ana_analog_mode = ~ana_dir_q & ~ana_latch_q
        & {PORT_W{~conv_sel_q}}; // R7
    // Latch 0 with flag 1 reads fixed zero, covering the reset state
    assign o_ana_digital_in = ana_flt_q & ana_in_mode; // R3 R7
    assign o_ana_conv_en = ana_analog_mode; // R7
    assign o_ana_pin = ana_latch_q; // R18
    assign o_ana_pin_oe = ana_dir_q; // R1 R7

    // Output bits read the latch, input bits the pin, others zero
    assign ana_rd = (ana_dir_q & ana_latch_q)
        | (ana_in_mode & ana_flt_q); // R8

    // Segment port: LCD route wins over general I/O
    assign o_seg_lcd_route = seg_sel_q; // R15
    assign o_seg_pin = seg_latch_q & ~seg_sel_q; // R18
    // Open-drain style: only a latched zero pulls, a one releases as input
    assign o_seg_pin_oe = ~seg_latch_q & ~seg_sel_q; // R15 R18

    always_comb begin
        rd_d = MAL_RD_UNMAPPED;
        case (idx)
            MAL_IDX_ANA_LATCH: rd_d = zext(ana_rd); // R8
            MAL_IDX_SEG_LATCH: rd_d = zext(seg_latch_q); // R16
            MAL_IDX_ANA_DIR: rd_d = zext(ana_dir_q);
            // Segment-routed bits return the filtered pin, undefined to software
            MAL_IDX_SEG_PIN: rd_d = zext(seg_flt_q); // R16 R17
            MAL_IDX_SEG_SEL: rd_d = zext(seg_sel_q);
            MAL_IDX_CONV_CTRL: rd_d = {31'h0000_0000, conv_sel_q};
            default: rd_d = MAL_RD_UNMAPPED;
        endcase
    end

    // Reads take one wait cycle so read data come from a flip-flop
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_pend_q <= 1'b0;
            rd_q <= 32'h0000_0000;
        end else begin
            rd_pend_q <= rd_start;
            if (rd_start) begin
                rd_q <= rd_d;
            end
        end
    end

    assign rd_start = i_avs_read && !rd_pend_q;
    assign o_avs_waitrequest = rd_start;
    assign o_avs_readdata = rd_q;

    // Register file, read handshake and pin mode checks
    property p_rst_defaults;
        @(posedge i_clk)
        $past(i_sys_rst) |-> ana_dir_q == MAL_RST_ANA_DIR
            && ana_latch_q == MAL_RST_ANA_LATCH
            && conv_sel_q == MAL_RST_CONV_SEL
            && seg_latch_q == MAL_RST_SEG_LATCH
            && seg_sel_q == MAL_RST_SEG_SEL;
    endproperty
    a_rst_defaults: assert property (p_rst_defaults) // R2 R13
        else $error("reset values wrong");

    property p_rst_zero_in;
        @(posedge i_clk) disable iff (i_sys_rst)
        (conv_sel_q && ana_latch_q == '0 && ana_dir_q == '0)
            |-> o_ana_digital_in == '0;
    endproperty
    a_rst_zero_in: assert property (p_rst_zero_in) // R3
        else $error("reset-mode input not zero");

    property p_out_drive;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_ana_pin_oe == ana_dir_q
            && (o_ana_pin & ana_dir_q) == (ana_latch_q & ana_dir_q);
    endproperty
    a_out_drive: assert property (p_out_drive) // R18
        else $error("output drive not from latch");

    property p_ana_read_zero;
        @(posedge i_clk) disable iff (i_sys_rst)
        (rd_start && idx == MAL_IDX_ANA_LATCH)
            |=> (o_avs_readdata[PORT_W-1:0]
            & $past(ana_analog_mode)) == '0;
    endproperty
    a_ana_read_zero: assert property (p_ana_read_zero) // R8
        else $error("analog bit read nonzero");

    property p_lat_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_lane0 && idx == MAL_IDX_ANA_LATCH)
            |=> ana_latch_q == $past(i_avs_writedata[PORT_W-1:0]);
    endproperty
    a_lat_write: assert property (p_lat_write) // R18
        else $error("latch write lost");

    property p_seg_route;
        @(posedge i_clk) disable iff (i_sys_rst)
        (o_seg_pin_oe & seg_sel_q) == '0;
    endproperty
    a_seg_route: assert property (p_seg_route) // R15
        else $error("LCD pin enabled by port");

    property p_seg_pin_rd;
        @(posedge i_clk) disable iff (i_sys_rst)
        (rd_start && idx == MAL_IDX_SEG_PIN)
            |=> o_avs_readdata[PORT_W-1:0] == $past(seg_flt_q);
    endproperty
    a_seg_pin_rd: assert property (p_seg_pin_rd) // R16 R17
        else $error("pin read wrong");

    property p_dig_in;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_ana_digital_in == (ana_flt_q & ~ana_dir_q & ana_latch_q);
    endproperty
    a_dig_in: assert property (p_dig_in) // R7
        else $error("input mode wrong");

    property p_rd_wait;
        @(posedge i_clk) disable iff (i_sys_rst)
        rd_start |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
    endproperty
    a_rd_wait: assert property (p_rd_wait) // R16
        else $error("read wait not one cycle");

    property p_conv_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        conv_sel_q |-> o_ana_conv_en == '0;
    endproperty
    a_conv_off: assert property (p_conv_off) // R7
        else $error("converter pin while flag set");

    // A converter pin must never be driven nor be a digital input
    property p_conv_excl;
        @(posedge i_clk) disable iff (i_sys_rst)
        (o_ana_conv_en & (ana_dir_q | ana_latch_q)) == '0;
    endproperty
    a_conv_excl: assert property (p_conv_excl) // R7
        else $error("converter pin in wrong mode");

    property p_dir_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_lane0 && idx == MAL_IDX_ANA_DIR)
            |=> ana_dir_q == $past(i_avs_writedata[PORT_W-1:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) // R1
        else $error("direction write lost");

    property p_seg_lat_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_lane0 && idx == MAL_IDX_SEG_LATCH)
            |=> seg_latch_q == $past(i_avs_writedata[PORT_W-1:0]);
    endproperty
    a_seg_lat_write: assert property (p_seg_lat_write) // R18
        else $error("segment latch write lost");

    property p_sel_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_lane0 && idx == MAL_IDX_SEG_SEL)
            |=> o_seg_lcd_route == $past(i_avs_writedata[PORT_W-1:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) // R15
        else $error("segment select write lost");

    property p_conv_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_lane0 && idx == MAL_IDX_CONV_CTRL)
            |=> conv_sel_q == $past(i_avs_writedata[MAL_CONV_SEL_BIT]);
    endproperty
    a_conv_write: assert property (p_conv_write) // R7
        else $error("converter flag write lost");

    // Only lane zero carries a register, other lanes must change nothing
    property p_be_guard;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_avs_write && !i_avs_byteenable[0])
            |=> $stable(ana_latch_q) && $stable(ana_dir_q)
            && $stable(conv_sel_q) && $stable(seg_latch_q)
            && $stable(seg_sel_q);
    endproperty
    a_be_guard: assert property (p_be_guard)
        else $error("write without lane zero stored");

    property p_wr_no_wait;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_avs_write |-> !o_avs_waitrequest;
    endproperty
    a_wr_no_wait: assert property (p_wr_no_wait)
        else $error("write stalled");

    // Read data must stand until the next read is captured
    property p_rd_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        !rd_start |=> $stable(o_avs_readdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without read");

    property p_lcd_pin_drive;
        @(posedge i_clk) disable iff (i_sys_rst)
        (o_seg_pin & seg_sel_q) == '0;
    endproperty
    a_lcd_pin_drive: assert property (p_lcd_pin_drive) // R15
        else $error("LCD pin carries port data");

    property p_seg_rd_latch;
        @(posedge i_clk) disable iff (i_sys_rst)
        (rd_start && idx == MAL_IDX_SEG_LATCH)
            |=> o_avs_readdata[PORT_W-1:0] == $past(seg_latch_q);
    endproperty
    a_seg_rd_latch: assert property (p_seg_rd_latch) // R16
        else $error("segment latch read wrong");

    property p_ana_out_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        (rd_start && idx == MAL_IDX_ANA_LATCH)
            |=> (o_avs_readdata[PORT_W-1:0] & $past(ana_dir_q))
            == $past(ana_latch_q & ana_dir_q);
    endproperty
    a_ana_out_read: assert property (p_ana_out_read) // R7
        else $error("output bit read not latch");
endmodule : mal_io_ports

// >>> mal_pin_model.sv
// Purpose: Pin-side model for both ports of the io block
// Assumes: A pin not driven by the block follows its outside level
// Notes: LCD-routed pins are left to the outside level here
`timescale 1ns/100ps
module mal_pin_model (
    input wire logic [7:0] i_ana_ext, // Outside level, analog port
    input wire logic [7:0] i_ana_drv, // Block drive, analog port
    input wire logic [7:0] i_ana_oe, // Block enable, analog port
    input wire logic [7:0] i_seg_ext, // Outside level, segment port
    input wire logic [7:0] i_seg_drv, // Block drive, segment port
    input wire logic [7:0] i_seg_oe, // Block enable, segment port
    output logic [7:0] o_ana_wire, // Resolved analog pins
    output logic [7:0] o_seg_wire // Resolved segment pins
);
    // Enabled bits win so a driven pin reads back its own latch
    assign o_ana_wire = (i_ana_oe & i_ana_drv) | (~i_ana_oe & i_ana_ext);
    assign o_seg_wire = (i_seg_oe & i_seg_drv) | (~i_seg_oe & i_seg_ext);
endmodule : mal_pin_model

// >>> tb_top.sv
// Purpose: Self-checking bench for the analog and segment ports
// Assumes: Read answer within a few cycles, writes take no wait
// Notes: Pin input filter lag is covered by idle cycles
`timescale 1ns/100ps
module tb_top;
    import mal_pkg::*;
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] ex;
        logic [7:0] mk;
    } mal_row_t;
    logic i_clk, i_sys_rst, rd_q, wr_q;
    logic [7:0] adr, ana_ext, seg_ext, ana_o, ana_oe, seg_o, seg_oe;
    logic [7:0] ana_w, seg_w, dig, conv, route, d;
    logic [31:0] wdat, rdat;
    logic [3:0] be;
    logic wreq;
    int n_mismatch, cmp_count;
    mal_row_t rows [6];
    mal_io_ports DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_avs_address(adr), .i_avs_read(rd_q), .i_avs_write(wr_q),
        .i_avs_writedata(wdat), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_ana_pin(ana_w), .o_ana_pin(ana_o), .o_ana_pin_oe(ana_oe),
        .o_ana_digital_in(dig), .o_ana_conv_en(conv),
        .i_seg_pin(seg_w), .o_seg_pin(seg_o), .o_seg_pin_oe(seg_oe),
        .o_seg_lcd_route(route));
    mal_pin_model PINS (.i_ana_ext(ana_ext), .i_ana_drv(ana_o),
        .i_ana_oe(ana_oe), .i_seg_ext(seg_ext), .i_seg_drv(seg_o),
        .i_seg_oe(seg_oe), .o_ana_wire(ana_w), .o_seg_wire(seg_w));
    task close_out;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low at an edge
    task bus(input logic w, input logic [5:0] idx, input logic [7:0] v,
             input logic [3:0] b);
        int n;
        @(posedge i_clk);
        adr <= {idx, 2'b00};
        wdat <= {24'h00_0000, v};
        be <= b;
        wr_q <= w;
        rd_q <= !w;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
            if (n > 20) begin
                n_mismatch++;
                close_out();
            end
        end while (wreq !== 1'b0);
        d = rdat[7:0];
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask : bus
    task rdc(input logic [5:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00, 4'hf);
        chk(d, ex);
    endtask : rdc
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        repeat (2000) @(posedge i_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        i_sys_rst = 1'b1;
        {rd_q, wr_q, adr, wdat, be} = '0;
        ana_ext = 8'h00;
        seg_ext = 8'hff;
        rows[0] = {MAL_IDX_ANA_DIR, 8'ha5, 8'ha5, 8'hff};
        rows[1] = {MAL_IDX_ANA_LATCH, 8'h3c, 8'h24, 8'hff};
        rows[2] = {MAL_IDX_SEG_LATCH, 8'h5a, 8'h5a, 8'hff};
        rows[3] = {MAL_IDX_SEG_SEL, 8'h0f, 8'h0f, 8'hff};
        rows[4] = {6'h3f, 8'hff, 8'h00, 8'hff};
        rows[5] = {MAL_IDX_SEG_PIN, 8'hff, 8'h5f, 8'hf0};
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(MAL_IDX_ANA_LATCH, 8'h00);
        rdc(MAL_IDX_SEG_LATCH, 8'hff);
        rdc(MAL_IDX_ANA_DIR, 8'h00);
        rdc(MAL_IDX_CONV_CTRL, 8'h01);
        chk(dig | conv | ana_oe | seg_oe, 8'h00);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, rows[i].idx, rows[i].wd, 4'h1);
            bus(1'b0, rows[i].idx, 8'h00, 4'hf);
            chk(d & rows[i].mk, rows[i].ex & rows[i].mk);
        end
        bus(1'b1, MAL_IDX_ANA_DIR, 8'h00, 4'h1);
        bus(1'b1, MAL_IDX_ANA_LATCH, 8'hff, 4'h1);
        bus(1'b1, MAL_IDX_CONV_CTRL, 8'h01, 4'h1);
        ana_ext <= 8'h96;
        repeat (8) @(posedge i_clk);
        chk(dig, 8'h96);
        rdc(MAL_IDX_ANA_LATCH, 8'h96);
        bus(1'b1, MAL_IDX_ANA_LATCH, 8'hf0, 4'h1);
        chk(conv, 8'h00);
        bus(1'b1, MAL_IDX_CONV_CTRL, 8'h00, 4'h1);
        @(negedge i_clk);
        chk(conv, 8'h0f);
        rdc(MAL_IDX_ANA_LATCH, 8'h90);
        // Leave converter use before any pin becomes an output
        bus(1'b1, MAL_IDX_CONV_CTRL, 8'h01, 4'h1);
        @(negedge i_clk);
        chk(conv, 8'h00);
        bus(1'b1, MAL_IDX_ANA_DIR, 8'hff, 4'h1);
        bus(1'b1, MAL_IDX_ANA_LATCH, 8'h3c, 4'h1);
        @(negedge i_clk);
        chk(ana_o & ana_oe, 8'h3c);
        chk(conv | dig, 8'h00);
        bus(1'b1, MAL_IDX_SEG_LATCH, 8'h00, 4'he);
        rdc(MAL_IDX_SEG_LATCH, 8'h5a);
        chk(seg_o | seg_oe, 8'hf0);
        chk(route, 8'h0f);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(MAL_IDX_SEG_LATCH, 8'hff);
        rdc(MAL_IDX_CONV_CTRL, 8'h01);
        chk(ana_oe | route, 8'h00);
        close_out();
    end
endmodule : tb_top
